// file: rtl/swg_global_regs.sv
// Global identification, start control and first global control register of the switch
`timescale 1ns/1ps

// Contract
// - Family ident byte at offset zero, read-only
// - Chip ident nibble and revision, read-only
// - Serial/reserved modes run only after start
// - EEPROM mode starts itself after load attempt
// - EEPROM applied only when both codes match
// - Start bit reads zero after reset
// - Tag priority >= base gives high class
// - MII enable zero tristates MII outputs
// - Share bit off limits ports to fifth
module swg_global_regs #(
   parameter logic [7:0] FAMILY_CODE = 8'h5A,  // Arbitrary identity value
   parameter logic [3:0] CHIP_CODE   = 4'hA,   // Arbitrary identity value
   parameter logic [2:0] REV_CODE    = 3'h3,   // Arbitrary identity value
   parameter int         POOL_W      = 16,
   parameter int         POOL_SIZE   = 512
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   input  wire logic                 cfgSelectHigh,
   input  wire logic                 cfgSelectLow,
   input  wire logic                 phyMiiEnableStrap,
   input  wire swg_pkg::swg_reg_req_t regReq,
   output logic      [7:0]           regRdData,
   output logic                      regRdValid,
   output logic                      eepromLoadReq,
   input  wire logic                 eepromAbsent,
   input  wire swg_pkg::swg_ee_beat_t eeBeat,
   input  wire logic                 tagValid,
   input  wire logic [2:0]           tagUserPrio,
   output logic                      prioValid,
   output logic                      prioHigh,
   output logic                      phyMiiOutEn_n,
   output logic                      bufShareAll,
   output logic      [POOL_W-1:0]    portBufLimit,
   output logic                      switchRun,
   output logic                      cfgTestMode
);

   localparam logic [POOL_W-1:0] LIMIT_FULL  = POOL_W'(POOL_SIZE);
   localparam logic [POOL_W-1:0] LIMIT_FIFTH = POOL_W'(POOL_SIZE / swg_pkg::SHARE_DIV);

   // ****************************************
   // Pin synchronisation
   // ****************************************
   logic [2:0] pinSync;
   logic [1:0] cfgMode;
   logic       strapSync;

   swg_sync #(.WIDTH(3)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pinIn   ({cfgSelectHigh, cfgSelectLow, phyMiiEnableStrap}),
      .pinSync (pinSync)
   );

   assign cfgMode   = pinSync[2:1];
   assign strapSync = pinSync[0];

   // ****************************************
   // Register state
   // ****************************************
   logic       startBit;
   logic       rsvdBit;
   logic [2:0] basePrio;
   logic       phyMiiEn;
   logic       bufShare;
   logic       famOk;
   logic       chipOk;
   logic       hostWrGctrl;
   logic       eeWrGctrl;

   swg_pkg::swg_boot_t state;
   logic [1:0]         settleCnt;

   assign hostWrGctrl = regReq.wr && (regReq.addr == swg_pkg::ADDR_GCTRL0);
   assign eeWrGctrl   = (state == swg_pkg::ST_EE_WAIT) && eeBeat.valid
                        && (eeBeat.idx == swg_pkg::EE_IDX_GCTRL0) && famOk && chipOk;

   // ****************************************
   // Boot sequencing
   // ****************************************
   // Pins are judged only once the synchroniser has filled, never at the reset edge
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state         <= swg_pkg::ST_SETTLE;
         settleCnt     <= 2'h0;
         eepromLoadReq <= 1'b0;
      end else begin
         eepromLoadReq <= 1'b0;
         case (state)
            swg_pkg::ST_SETTLE: begin
               settleCnt <= settleCnt + 2'h1;
               if (settleCnt == 2'(swg_pkg::SYNC_STAGES)) begin
                  state <= swg_pkg::ST_DECIDE;
               end
            end
            swg_pkg::ST_DECIDE: begin
               case (cfgMode)
                  swg_pkg::CFG_EEPROM: begin
                     state         <= swg_pkg::ST_EE_WAIT;
                     eepromLoadReq <= 1'b1;
                  end
                  swg_pkg::CFG_RSVD,
                  swg_pkg::CFG_SPI: state <= swg_pkg::ST_HOST;
                  default: state <= swg_pkg::ST_TEST;
               endcase
            end
            swg_pkg::ST_EE_WAIT: begin
               if (eepromAbsent || (eeBeat.valid && eeBeat.last)) begin
                  state <= swg_pkg::ST_AUTO;
               end
            end
            swg_pkg::ST_AUTO: state <= swg_pkg::ST_AUTO;
            swg_pkg::ST_HOST: state <= swg_pkg::ST_HOST;
            swg_pkg::ST_TEST: state <= swg_pkg::ST_TEST;
            default: state <= swg_pkg::ST_SETTLE;
         endcase
      end
   end

   // ****************************************
   // EEPROM identity check
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         famOk  <= 1'b0;
         chipOk <= 1'b0;
      end else if (state == swg_pkg::ST_EE_WAIT && eeBeat.valid) begin
         if (eeBeat.idx == swg_pkg::EE_IDX_FAMILY) begin
            famOk <= (eeBeat.data == FAMILY_CODE);
         end
         if (eeBeat.idx == swg_pkg::EE_IDX_CHIP) begin
            chipOk <= (eeBeat.data[7:swg_pkg::CHIP_LSB] == CHIP_CODE);
         end
      end
   end

   // ****************************************
   // Start bit
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         startBit <= swg_pkg::START_RST;
      end else if (regReq.wr && regReq.addr == swg_pkg::ADDR_CHIP_START) begin
         startBit <= regReq.wdata[swg_pkg::START_BIT];
      end
   end

   // ****************************************
   // Global control 0
   // ****************************************
   // A host write in the same cycle as an EEPROM byte wins, host intent is newer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rsvdBit  <= swg_pkg::RSVD_RST;
         basePrio <= swg_pkg::PRIO_RST;
         phyMiiEn <= swg_pkg::PHY_EN_RST;
         bufShare <= swg_pkg::BUF_SHARE_RST;
      end else if (hostWrGctrl) begin
         rsvdBit  <= regReq.wdata[swg_pkg::RSVD_BIT];
         basePrio <= regReq.wdata[swg_pkg::PRIO_LSB +: 3];
         phyMiiEn <= regReq.wdata[swg_pkg::PHY_EN_BIT];
         bufShare <= regReq.wdata[swg_pkg::BUF_SHARE_BIT];
      end else if (eeWrGctrl) begin
         rsvdBit  <= eeBeat.data[swg_pkg::RSVD_BIT];
         basePrio <= eeBeat.data[swg_pkg::PRIO_LSB +: 3];
         phyMiiEn <= eeBeat.data[swg_pkg::PHY_EN_BIT];
         bufShare <= eeBeat.data[swg_pkg::BUF_SHARE_BIT];
      end else if (state == swg_pkg::ST_DECIDE) begin
         phyMiiEn <= strapSync;
      end
   end

   // ****************************************
   // Register read port
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         regRdData  <= swg_pkg::ZERO_BYTE;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regReq.rd;
         case (regReq.addr)
            swg_pkg::ADDR_FAMILY: regRdData <= FAMILY_CODE;
            swg_pkg::ADDR_CHIP_START: regRdData <= {CHIP_CODE, REV_CODE, startBit};
            swg_pkg::ADDR_GCTRL0: regRdData <= {rsvdBit, basePrio, phyMiiEn, bufShare, {swg_pkg::BUF_SHARE_BIT{1'b0}}};
            default: regRdData <= swg_pkg::ZERO_BYTE;
         endcase
      end
   end

   // ****************************************
   // Switch-facing controls
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         switchRun   <= 1'b0;
         cfgTestMode <= 1'b0;
      end else begin
         switchRun   <= (state == swg_pkg::ST_AUTO) || ((state == swg_pkg::ST_HOST) && startBit);
         cfgTestMode <= (state == swg_pkg::ST_TEST);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         prioValid <= 1'b0;
         prioHigh  <= 1'b0;
      end else begin
         prioValid <= tagValid;
         prioHigh  <= tagValid && (tagUserPrio >= basePrio);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         phyMiiOutEn_n <= 1'b1;
         bufShareAll   <= swg_pkg::BUF_SHARE_RST;
         portBufLimit  <= LIMIT_FULL;
      end else begin
         phyMiiOutEn_n <= !phyMiiEn;
         bufShareAll   <= bufShare;
         portBufLimit  <= bufShare ? LIMIT_FULL : LIMIT_FIFTH;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_family_ro;
      regReq.rd && regReq.addr == swg_pkg::ADDR_FAMILY |=> regRdValid && regRdData == FAMILY_CODE;
   endproperty
   a_family_ro: assert property (p_family_ro) else $error("family ident read wrong");

   property p_chip_rev;
      regReq.rd && regReq.addr == swg_pkg::ADDR_CHIP_START
         |=> regRdData[7:swg_pkg::CHIP_LSB] == CHIP_CODE
             && regRdData[swg_pkg::CHIP_LSB-1:swg_pkg::REV_LSB] == REV_CODE;
   endproperty
   a_chip_rev: assert property (p_chip_rev) else $error("chip or revision ident wrong");

   property p_host_hold;
      state == swg_pkg::ST_HOST && !startBit |=> !switchRun;
   endproperty
   a_host_hold: assert property (p_host_hold) else $error("switch ran without start");

   property p_auto_start;
      state == swg_pkg::ST_EE_WAIT && eepromAbsent |=> ##1 switchRun;
   endproperty
   a_auto_start: assert property (p_auto_start) else $error("no auto start without eeprom");

   property p_ee_reject;
      eeBeat.valid && eeBeat.idx == swg_pkg::EE_IDX_GCTRL0 && !(famOk && chipOk) && !hostWrGctrl
         |=> $stable(basePrio) && $stable(bufShare);
   endproperty
   a_ee_reject: assert property (p_ee_reject) else $error("unmatched eeprom applied");

   property p_start_reset;
      $rose(rst_n) |-> !startBit && !switchRun;
   endproperty
   a_start_reset: assert property (@(posedge clk_sys) p_start_reset) else $error("start set after reset");

   property p_prio_class;
      tagValid |=> prioValid && prioHigh == ($past(tagUserPrio) >= $past(basePrio));
   endproperty
   a_prio_class: assert property (p_prio_class) else $error("priority class wrong");

   property p_mii_tristate;
      !phyMiiEn |=> phyMiiOutEn_n;
   endproperty
   a_mii_tristate: assert property (p_mii_tristate) else $error("mii driven while disabled");

   property p_buf_limit;
      !bufShare |=> portBufLimit == LIMIT_FIFTH && !bufShareAll;
   endproperty
   a_buf_limit: assert property (p_buf_limit) else $error("buffer limit wrong");

   property p_rsvd_back;
      regReq.rd && regReq.addr == swg_pkg::ADDR_GCTRL0 |=> regRdData[swg_pkg::RSVD_BIT] == $past(rsvdBit);
   endproperty
   a_rsvd_back: assert property (p_rsvd_back) else $error("reserved bit readback wrong");

   c_ee_boot:   cover property (state == swg_pkg::ST_EE_WAIT ##[1:50] state == swg_pkg::ST_AUTO);
   c_host_run:  cover property (state == swg_pkg::ST_HOST && startBit ##1 switchRun);
   c_ee_apply:  cover property (eeWrGctrl);
   c_prio_high: cover property (prioValid && prioHigh);

endmodule : swg_global_regs

// file: pkg/swg_pkg.sv
// Constants, types and carriers shared by the global identity and control register block
package swg_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] ADDR_FAMILY     = 8'h00;
   localparam logic [7:0] ADDR_CHIP_START = 8'h01;
   localparam logic [7:0] ADDR_GCTRL0     = 8'h02;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CHIP_LSB      = 4;
   localparam int REV_LSB       = 1;
   localparam int START_BIT     = 0;
   localparam int RSVD_BIT      = 7;
   localparam int PRIO_LSB      = 4;
   localparam int PHY_EN_BIT    = 3;
   localparam int BUF_SHARE_BIT = 2;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [2:0] PRIO_RST      = 3'h4;
   localparam logic       BUF_SHARE_RST = 1'b1;
   localparam logic       RSVD_RST      = 1'b0;
   localparam logic       START_RST     = 1'b0;
   localparam logic       PHY_EN_RST    = 1'b1;
   localparam logic [7:0] ZERO_BYTE     = 8'h00;

   // ****************************************
   // Configuration pin modes and sharing
   // ****************************************
   localparam logic [1:0] CFG_EEPROM = 2'h0;
   localparam logic [1:0] CFG_RSVD   = 2'h1;
   localparam logic [1:0] CFG_SPI    = 2'h2;
   localparam logic [1:0] CFG_TEST   = 2'h3;
   localparam int         SHARE_DIV  = 5;
   localparam int         SYNC_STAGES = 2;

   // EEPROM byte positions inside the load stream
   localparam logic [7:0] EE_IDX_FAMILY = 8'h00;
   localparam logic [7:0] EE_IDX_CHIP   = 8'h01;
   localparam logic [7:0] EE_IDX_GCTRL0 = 8'h02;

   typedef enum logic [2:0] {
      ST_SETTLE,
      ST_DECIDE,
      ST_EE_WAIT,
      ST_AUTO,
      ST_HOST,
      ST_TEST
   } swg_boot_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } swg_reg_req_t;

   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] idx;
      logic [7:0] data;
   } swg_ee_beat_t;

endpackage : swg_pkg

// file: rtl/swg_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps

module swg_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] pinSync
);

   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second stage
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            stage1[i]  <= 1'b0;
            pinSync[i] <= 1'b0;
         end else begin
            stage1[i]  <= pinIn[i];
            pinSync[i] <= stage1[i];
         end
      end
   end

endmodule : swg_sync

// file: tb/swg_ee_model.sv
// Boot EEPROM stand-in that streams family, chip and control bytes on request
`timescale 1ns/1ps

module swg_ee_model (
   input  wire logic             clk_sys,
   input  wire logic             loadReq,
   input  wire logic             present,
   input  wire logic             slow,
   input  wire logic [23:0]      image,
   output swg_pkg::swg_ee_beat_t eeBeat,
   output logic                  absent
);
   logic [1:0] cnt;
   logic       gap;

   initial begin
      eeBeat = '0;
      absent = 1'b0;
      cnt    = 2'h0;
      gap    = 1'b0;
   end

   // Idle beats carry inverted junk so a stale byte can never look valid
   always @(negedge clk_sys) begin
      absent <= loadReq && !present;
      gap    <= slow && !gap;
      if (cnt != 2'h0 && !gap) begin
         eeBeat <= '{1'b1, cnt == 2'h3, {6'h0, cnt - 2'h1}, image[8*(3-cnt) +: 8]};
         cnt    <= (cnt == 2'h3) ? 2'h0 : cnt + 2'h1;
      end else begin
         eeBeat <= '{1'b0, 1'b0, ~eeBeat.idx, ~eeBeat.data};
         if (loadReq && present) begin
            cnt <= 2'h1;
         end
      end
   end
endmodule : swg_ee_model

// file: tb/tb_top.sv
// Self-checking bench for the global identity and control registers
`timescale 1ns/1ps

module tb_top;
   localparam logic [7:0] FAM  = 8'h3C;  // Arbitrary identity value
   localparam logic [3:0] CHP  = 4'h6;   // Arbitrary identity value
   localparam logic [2:0] REV  = 3'h5;   // Arbitrary identity value
   localparam int         POOL = 512;

   logic                  clk_sys, rst_n, cfgHigh, cfgLow, strap, eeLoad, eeAbsent;
   logic                  tagValid, prioValid, prioHigh, phyMiiOutEn_n, bufShareAll;
   logic                  switchRun, cfgTestMode, eePresent, eeSlow, regRdValid;
   logic [2:0]            tagPrio;
   logic [7:0]            regRdData, v;
   logic [15:0]           portBufLimit;
   logic [23:0]           eeImage;
   logic [31:0]           rng;
   swg_pkg::swg_reg_req_t regReq;
   swg_pkg::swg_ee_beat_t eeBeat;
   int                    nMismatch, numChecks;

   swg_global_regs #(.FAMILY_CODE(FAM), .CHIP_CODE(CHP), .REV_CODE(REV), .POOL_W(16), .POOL_SIZE(POOL)) dut_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .cfgSelectHigh(cfgHigh), .cfgSelectLow(cfgLow),
      .phyMiiEnableStrap(strap), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
      .eepromLoadReq(eeLoad), .eepromAbsent(eeAbsent), .eeBeat(eeBeat), .tagValid(tagValid),
      .tagUserPrio(tagPrio), .prioValid(prioValid), .prioHigh(prioHigh), .phyMiiOutEn_n(phyMiiOutEn_n),
      .bufShareAll(bufShareAll), .portBufLimit(portBufLimit), .switchRun(switchRun), .cfgTestMode(cfgTestMode));

   swg_ee_model ee_u (.clk_sys(clk_sys), .loadReq(eeLoad), .present(eePresent), .slow(eeSlow),
      .image(eeImage), .eeBeat(eeBeat), .absent(eeAbsent));

   always #5 clk_sys = ~clk_sys;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction : xs

   function automatic logic [7:0] gc0Def(input logic s);
      return {1'b0, 3'h4, s, 1'b1, 2'h0};
   endfunction : gc0Def

   function automatic logic [15:0] limitOf(input logic share);
      return share ? 16'(POOL) : 16'(POOL / swg_pkg::SHARE_DIV);
   endfunction : limitOf

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nMismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Request stays up until the next call or idle, so accesses can run back to back
   task automatic acc(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
      regReq = '{r, w, a, d};
      @(negedge clk_sys);
   endtask : acc

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b1, 1'b0, a, 8'h00);
      chk(16'(regRdValid), 16'h0001);
      chk(16'(regRdData), 16'(exp));
   endtask : rd

   task automatic idle();
      regReq = '0;
      @(negedge clk_sys);
   endtask : idle

   task automatic boot(input logic [1:0] mode, input logic pres, input logic slw, input logic [23:0] img);
      {cfgHigh, cfgLow} = mode;
      strap             = xs() > 8'h40;
      eePresent         = pres;
      eeSlow            = slw;
      eeImage           = img;
      rst_n             = 1'b0;
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (8) @(negedge clk_sys);
   endtask : boot

   task automatic waitRun();
      int i;
      i = 0;
      while (switchRun !== 1'b1 && i < 60) begin
         @(negedge clk_sys);
         i++;
      end
   endtask : waitRun

   task automatic endSim();
      $display("checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : endSim

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      rst_n = 1'b0;
      {cfgHigh, cfgLow, strap, tagValid, tagPrio} = '0;
      {eePresent, eeSlow, eeImage} = '0;
      regReq = '0;
      rng = 32'h8C4E;
      nMismatch = 0;
      numChecks = 0;
      boot(swg_pkg::CFG_SPI, 1'b0, 1'b0, 24'h0);
      rd(8'h00, FAM);
      rd(8'h01, {CHP, REV, 1'b0});
      rd(8'h02, gc0Def(strap));
      chk(16'(switchRun), 16'h0000);
      acc(1'b0, 1'b1, 8'h00, 8'hFF);
      rd(8'h00, FAM);
      acc(1'b0, 1'b1, 8'h01, 8'hFF);
      rd(8'h01, {CHP, REV, 1'b1});
      chk(16'(switchRun), 16'h0001);
      rd(8'h05, 8'h00);
      for (int k = 0; k < 10; k++) begin
         v = (k < 2) ? {k[0], 7'h0} : xs();
         acc(1'b0, 1'b1, 8'h02, v);
         // Bits 1-0 of this register are not implemented here and read zero
         rd(8'h02, {v[7:2], 2'h0});
         chk(16'(bufShareAll), 16'(v[2]));
         chk(portBufLimit, limitOf(v[2]));
         chk(16'(phyMiiOutEn_n), 16'(!v[3]));
         for (int p = 0; p < 8; p++) begin
            regReq = '0;
            tagValid = 1'b1;
            tagPrio = 3'(p);
            @(negedge clk_sys);
            chk(16'({prioValid, prioHigh}), 16'({1'b1, 3'(p) >= v[6:4]}));
         end
         tagValid = 1'b0;
      end
      acc(1'b0, 1'b1, 8'h01, 8'h00);
      idle();
      chk(16'(switchRun), 16'h0000);
      $display("test host mode done");
      boot(swg_pkg::CFG_RSVD, 1'b0, 1'b0, 24'h0);
      repeat (20) @(negedge clk_sys);
      chk(16'(switchRun), 16'h0000);
      acc(1'b0, 1'b1, 8'h01, 8'h01);
      idle();
      chk(16'(switchRun), 16'h0001);
      $display("test reserved mode done");
      for (int k = 0; k < 4; k++) begin
         v = xs();
         boot(swg_pkg::CFG_EEPROM, k != 3, k[0], {(k == 1) ? ~FAM : FAM, (k == 2) ? ~CHP : CHP, 4'h9, v});
         waitRun();
         chk(16'(switchRun), 16'h0001);
         rd(8'h02, (k == 0) ? {v[7:2], 2'h0} : gc0Def(strap));
         rd(8'h01, {CHP, REV, 1'b0});
      end
      $display("test eeprom boot done");
      // test strap only here, never in normal runs
      boot(swg_pkg::CFG_TEST, 1'b0, 1'b0, 24'h0);
      repeat (20) @(negedge clk_sys);
      chk(16'({cfgTestMode, switchRun}), 16'h0002);
      $display("test strap mode done");
      endSim();
   end

   initial begin
      #200000;
      nMismatch++;
      $display("mismatch at %0t: watchdog expired", $time);
      endSim();
   end
endmodule : tb_top
